// File: rtl/tli_arbiter.sv
// Purpose: Picks winning request by level, then fixed order
// Assumes: Lower index wins within a level
// Notes: Pure combinational
`timescale 1ns/1ps
module tli_arbiter #(
  parameter int unsigned N = tli_pkg::NUM_SRC
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] high,
  output tli_pkg::tli_win_t win
);
  logic [N-1:0] hi_req;
  assign hi_req = req & high;

  always_comb begin
    win = '0;
    // Scan downward so the lowest index is the last to overwrite
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && !(|hi_req && !high[i])) begin
        win.valid = 1'b1;
        win.high = high[i];
        win.src = tli_pkg::SRC_W'(i);
      end
    end
  end
endmodule // tli_arbiter

// File: rtl/tli_ctrl.sv
// Purpose: Two-level interrupt handler with AXI4-Lite register port
// Assumes: Core asserts call_ack when it starts the call, return_from_interrupt_done after return
// Notes: Overview of operation
// Overview of operation
// - A source event sets its pending flag.
// - Flags set regardless of the source enable.
// - Enabled set flag raises a call request after current instruction.
// - Routines end in return; core resumes the interrupted instruction.
// - Disabled sources are ignored; execution continues.
// - Each source has its own enable bit in one of two enable registers.
// - Individual enables act only while the global enable bit is one.
// - Global enable zero blocks every request.
// - Flags raised while globally disabled stay pending until re-enabled.
// - Some flags clear on vectoring; others software clears.
// - A flag still set after return re-requests after one instruction.
// - Fifteen sources, each with vector and fixed order position.
// - Software writing one to a flag acts like a hardware event.
// - Per-source priority bit; all low after reset.
// - High preempts low; nothing preempts a running high routine.
// - Simultaneous requests: high level served first.
// - Same level: fixed order decides.
// - Requests sampled every cycle; fastest response five cycles.
// - Equal or lower request waits for return plus one instruction.
`timescale 1ns/1ps
module tli_ctrl #(
  parameter int unsigned N = tli_pkg::NUM_SRC,
  parameter logic [14:0] HW_CLEAR_MASK = 15'h000F
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N-1:0] src_event,
  output tli_pkg::tli_call_t call,
  input wire logic call_ack,
  input wire logic return_from_interrupt_done,
  input wire logic instr_done,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_HOLD = 2'b10
  } tli_state_t;

  logic [7:0] irq_enable_r;
  logic [7:0] ext_irq_enable_r;
  logic [7:0] irq_priority_reg_r;
  logic [7:0] ext_irq_priority_reg_r;
  logic [N-1:0] pending_r;
  logic [1:0] active_r;
  logic hold_off_r;
  tli_state_t state_r;
  logic [7:0] awaddr_r;
  logic aw_full_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_full_r;
  logic [N-1:0] src_en;
  logic [N-1:0] src_high;
  logic [N-1:0] req_vec;
  logic global_irq_enable;
  tli_pkg::tli_win_t win;
  logic win_ok;
  logic do_write;
  logic [N-1:0] sw_set;
  logic [N-1:0] sw_clr;
  logic [N-1:0] vec_clr;

  function automatic logic [tli_pkg::VEC_W-1:0] vec_of(input logic [tli_pkg::SRC_W-1:0] s);
    vec_of = tli_pkg::VEC_BASE + tli_pkg::VEC_STEP * tli_pkg::VEC_W'(s);
  endfunction

  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    sel = (a == off);
  endfunction

  assign global_irq_enable = irq_enable_r[tli_pkg::GLOBAL_EN_BIT];
  assign src_en = {ext_irq_enable_r, irq_enable_r[6:0]};
  assign src_high = {ext_irq_priority_reg_r, irq_priority_reg_r[6:0]};
  // Masked flags stay in pending_r, only the request is hidden
  assign req_vec = global_irq_enable ? (pending_r & src_en) : '0;

  tli_arbiter #(
    .N(N)
  ) u_arb (
    .req(req_vec),
    .high(src_high),
    .win(win)
  );

  // High may enter under low; nothing enters under high
  always_comb begin
    win_ok = 1'b0;
    if (win.valid && !hold_off_r) begin
      if (active_r == 2'b00) begin
        win_ok = 1'b1;
      end else if (active_r == 2'b01 && win.high) begin
        win_ok = 1'b1;
      end
    end
  end

  // Write path
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && !aw_full_r) begin
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && !w_full_r) begin
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tli_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (sel(awaddr_r, tli_pkg::OFF_IRQ_ENABLE) ||
                      sel(awaddr_r, tli_pkg::OFF_EXT_IRQ_ENABLE) ||
                      sel(awaddr_r, tli_pkg::OFF_PRIORITY) ||
                      sel(awaddr_r, tli_pkg::OFF_EXT_PRIORITY) ||
                      sel(awaddr_r, tli_pkg::OFF_PENDING) ||
                      sel(awaddr_r, tli_pkg::OFF_PEND_CLEAR) ||
                      sel(awaddr_r, tli_pkg::OFF_ACTIVE)) ?
                     tli_pkg::RESP_OKAY : tli_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lanes 0 and 1 carry register bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_r <= tli_pkg::REG_RESET;
      ext_irq_enable_r <= tli_pkg::REG_RESET;
      irq_priority_reg_r <= tli_pkg::REG_RESET;
      ext_irq_priority_reg_r <= tli_pkg::REG_RESET;
    end else if (do_write && wstrb_r[0]) begin
      if (sel(awaddr_r, tli_pkg::OFF_IRQ_ENABLE)) begin
        irq_enable_r <= wdata_r[7:0];
      end
      if (sel(awaddr_r, tli_pkg::OFF_EXT_IRQ_ENABLE)) begin
        ext_irq_enable_r <= wdata_r[7:0];
      end
      if (sel(awaddr_r, tli_pkg::OFF_PRIORITY)) begin
        irq_priority_reg_r <= {1'b0, wdata_r[6:0]};
      end
      if (sel(awaddr_r, tli_pkg::OFF_EXT_PRIORITY)) begin
        ext_irq_priority_reg_r <= wdata_r[7:0];
      end
    end
  end

  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (do_write && wstrb_r[0] && wstrb_r[1]) begin
      if (sel(awaddr_r, tli_pkg::OFF_PENDING)) begin
        sw_set = wdata_r[N-1:0];
      end
      if (sel(awaddr_r, tli_pkg::OFF_PEND_CLEAR)) begin
        sw_clr = wdata_r[N-1:0];
      end
    end
  end

  // Auto clear only for sources flagged in HW_CLEAR_MASK
  always_comb begin
    vec_clr = '0;
    if (call.req && call_ack) begin
      vec_clr[call.src] = HW_CLEAR_MASK[call.src];
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r & ~(sw_clr | vec_clr)) | src_event | sw_set;
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tli_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tli_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tli_pkg::OFF_IRQ_ENABLE: s_axi_rdata <= {24'h000000, irq_enable_r};
        tli_pkg::OFF_EXT_IRQ_ENABLE: s_axi_rdata <= {24'h000000, ext_irq_enable_r};
        tli_pkg::OFF_PRIORITY: s_axi_rdata <= {24'h000000, irq_priority_reg_r};
        tli_pkg::OFF_EXT_PRIORITY: s_axi_rdata <= {24'h000000, ext_irq_priority_reg_r};
        tli_pkg::OFF_PENDING: s_axi_rdata <= {17'h00000, pending_r};
        tli_pkg::OFF_PEND_CLEAR: s_axi_rdata <= '0;
        tli_pkg::OFF_ACTIVE: s_axi_rdata <= {30'h00000000, active_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= tli_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Request sequencer: one detect cycle, then hold until ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      call <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (win_ok) begin
            state_r <= ST_REQ;
            call.req <= 1'b1;
            call.src <= win.src;
            call.vector <= vec_of(win.src);
          end
        end
        ST_REQ: begin
          // Vector frozen so the core never sees it change mid-call
          if (call_ack) begin
            state_r <= ST_HOLD;
            call <= '0;
          end
        end
        ST_HOLD: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
          call <= '0;
        end
      endcase
    end
  end

  // Two-level active stack: bit0 low routine, bit1 high routine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 2'b00;
    end else if (call.req && call_ack) begin
      if (src_high[call.src]) begin
        active_r[1] <= 1'b1;
      end else begin
        active_r[0] <= 1'b1;
      end
    end else if (return_from_interrupt_done) begin
      if (active_r[1]) begin
        active_r[1] <= 1'b0;
      end else begin
        active_r[0] <= 1'b0;
      end
    end
  end

  // After a return one instruction must run before the next call
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_off_r <= 1'b0;
    end else if (return_from_interrupt_done) begin
      hold_off_r <= 1'b1;
    end else if (instr_done) begin
      hold_off_r <= 1'b0;
    end
  end
endmodule // tli_ctrl

// File: rtl/tli_pkg.sv
// Purpose: Shared constants and carriers for the two-level interrupt handler
// Assumes: 15 sources, 8-bit enable and priority registers
// Notes: Offsets are byte addresses on the AXI4-Lite register port
package tli_pkg;
  localparam int unsigned NUM_SRC = 15;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned VEC_W = 16;
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFF_EXT_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFF_PRIORITY = 8'h08;
  localparam logic [7:0] OFF_EXT_PRIORITY = 8'h0C;
  localparam logic [7:0] OFF_PENDING = 8'h10;
  localparam logic [7:0] OFF_PEND_CLEAR = 8'h14;
  localparam logic [7:0] OFF_ACTIVE = 8'h18;
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned LATENCY_CYC = 5;
  localparam int unsigned DETECT_CYC = 1;

  typedef struct packed {
    logic valid;
    logic high;
    logic [SRC_W-1:0] src;
  } tli_win_t;

  typedef struct packed {
    logic req;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] vector;
  } tli_call_t;
endpackage

// File: sim/test_two_level_interrupt_handler.sv
// Purpose: Self-checking bench for the interrupt handler
// Assumes: Core model answers calls, bench plays software
// Notes: Pending, enable and priority mirrored in bench vectors
`timescale 1ns/1ps
module test_two_level_interrupt_handler;
  localparam logic [14:0] CLR = 15'h000F;
  logic clk = 1'h0, rst_b = 1'h0, slow = 1'h0, ret_cmd = 1'h0, cl;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic aw_r, w_r, b_v, ar_r, r_v, call_ack, return_from_interrupt_done, instr_done;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d;
  logic [1:0] r_s, b_s;
  logic [14:0] src_event = 15'h0000, pend = 15'h0000, en, pr, mk;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 64, r, w;
  tli_pkg::tli_call_t call, c;
  tli_pkg::tli_call_t acks[$];
  tli_ctrl #(.HW_CLEAR_MASK(CLR)) u_dut (.clk, .rst_b, .src_event, .call, .call_ack,
    .return_from_interrupt_done, .instr_done, .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r));
  tli_core_model u_core (.clk, .rst_b, .call, .slow, .ret_cmd, .call_ack, .return_from_interrupt_done,
    .instr_done);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (call.req && call_ack) acks.push_back(call);
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e = tli_pkg::RESP_OKAY);
    @(posedge clk);
    {aw_a, w_d, aw_v, w_v, b_r} <= {a, d, 3'h7};
    do @(negedge clk); while (!(aw_r && w_r));
    @(posedge clk) {aw_v, w_v} <= 2'h0;
    do @(negedge clk); while (!b_v);
    chk("bresp", b_s, e);
    @(posedge clk) b_r <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    {ar_a, ar_v, r_r} <= {a, 2'h3};
    do @(negedge clk); while (!ar_r);
    @(posedge clk) ar_v <= 1'h0;
    do @(negedge clk); while (!r_v);
    chk("rdata", r_d, d);
    chk("rresp", r_s, e);
    @(posedge clk) r_r <= 1'h0;
  endtask
  task automatic ev(input logic [14:0] m);
    @(posedge clk) src_event <= m;
    @(posedge clk) src_event <= 15'h0000;
  endtask
  task automatic take(input int s);
    while (acks.size() == 0) @(posedge clk);
    c = acks.pop_front();
    chk("src", c.src, s);
    chk("vector", c.vector, tli_pkg::VEC_BASE + tli_pkg::VEC_STEP * s);
  endtask
  task automatic idle();
    repeat (12) @(posedge clk);
    chk("no call", acks.size(), 0);
  endtask
  task automatic ret();
    @(posedge clk) ret_cmd <= 1'h1;
    @(posedge clk) ret_cmd <= 1'h0;
  endtask
  function automatic int pick();
    for (int h = 1; h >= 0; h--)
      for (int i = 0; i < 15; i++)
        if (pend[i] && en[i] && pr[i] == h[0]) return i;
    return -1;
  endfunction
  // Uncleared flags are kept in the mirror, so the next pick expects re-entry
  task automatic drain();
    for (w = pick(); w >= 0; w = pick()) begin
      take(w);
      cl = 1'($random(seed));
      if (CLR[w] || cl) pend[w] = 1'h0;
      if (!CLR[w] && cl) wr(8'h14, 32'h1 << w);
      ret();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    for (r = 0; r < 28; r += 4) rd(r[7:0], 32'h0, tli_pkg::RESP_OKAY);
    rd(8'h1C, 32'h0, tli_pkg::RESP_SLVERR);
    wr(8'h1C, 32'hFF, tli_pkg::RESP_SLVERR);
    for (r = 0; r < 6; r++) begin
      mk = 15'($random(seed));
      en = 15'($random(seed));
      pr = 15'($random(seed));
      slow <= r[1];
      wr(8'h00, {25'h0, en[6:0]});
      wr(8'h04, {24'h0, en[14:7]});
      wr(8'h08, {25'h0, pr[6:0]});
      wr(8'h0C, {24'h0, pr[14:7]});
      if (r[0]) wr(8'h10, {17'h0, mk});
      else ev(mk);
      pend = pend | mk;
      idle();
      rd(8'h10, {17'h0, pend}, tli_pkg::RESP_OKAY);
      wr(8'h00, {24'h0, 1'h1, en[6:0]});
      drain();
      rd(8'h10, {17'h0, pend}, tli_pkg::RESP_OKAY);
    end
    wr(8'h14, 32'h7FFF);
    {en, pr} = {15'h7FFF, 15'h0200};
    // Loop left random low enables behind
    wr(8'h00, 32'hFF);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h4);
    wr(8'h04, 32'hFF);
    ev(15'h0020);
    // Flag lands one edge after the event, request one edge later
    @(negedge clk) chk("req early", call.req, 1'h0);
    @(negedge clk) chk("req", call.req, 1'h1);
    take(5);
    ev(15'h1000);
    idle();
    ev(15'h0200);
    take(9);
    rd(8'h18, 32'h3, tli_pkg::RESP_OKAY);
    ev(15'h0004);
    idle();
    wr(8'h14, 32'h0200);
    ret();
    idle();
    wr(8'h14, 32'h0020);
    pend = 15'h1004;
    ret();
    drain();
    report_and_stop();
  end
endmodule // test_two_level_interrupt_handler

// File: sim/tli_core_model.sv
// Purpose: Processor core model on the call link
// Assumes: One instruction ends each cycle, or each fourth when slow
// Notes: Returns only on command from the bench
`timescale 1ns/1ps
module tli_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input tli_pkg::tli_call_t call,
  input wire logic slow,
  input wire logic ret_cmd,
  output logic call_ack,
  output logic return_from_interrupt_done,
  output logic instr_done
);
  logic [1:0] cnt_r;
  logic ret_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_r, ret_r, call_ack, return_from_interrupt_done, instr_done} <= 6'h00;
    end else begin
      {call_ack, return_from_interrupt_done, instr_done} <= 3'h0;
      if (ret_cmd) ret_r <= 1'h1;
      if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
      else begin
        cnt_r <= {slow, slow};
        // Calls and returns only between instructions
        if (call.req && !call_ack) call_ack <= 1'h1;
        else if (ret_r) {return_from_interrupt_done, ret_r} <= 2'h2;
        else instr_done <= 1'h1;
      end
    end
  end
endmodule // tli_core_model

// File: sim/tli_ctrl_chk.sv
// Purpose: Port checker for the interrupt handler
// Assumes: Bound to tli_ctrl
// Notes: Watches the call link and bus answers
`timescale 1ns/1ps
module tli_ctrl_chk #(
  parameter int unsigned N = 15
) (
  input wire logic clk,
  input wire logic rst_b,
  input tli_pkg::tli_call_t call,
  input wire logic call_ack,
  input wire logic return_from_interrupt_done,
  input wire logic instr_done,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic [tli_pkg::VEC_W-1:0] exp_vec;
  assign exp_vec = tli_pkg::VEC_BASE + tli_pkg::VEC_STEP * tli_pkg::VEC_W'(call.src);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_req_holds: assert property (call.req && !call_ack |=> call.req && $stable(call))
    else $error("call moved before ack");
  a_vec_src: assert property (call.req |-> call.vector == exp_vec)
    else $error("bad vector");
  a_src_range: assert property (call.req |-> call.src < N)
    else $error("bad source");
  a_ack_drops: assert property (call.req && call_ack |=> !call.req)
    else $error("req after ack");
  a_return_from_interrupt_block: assert property (return_from_interrupt_done ##1 !instr_done |=> !$rose(call.req))
    else $error("req in return hold");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer kept");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer kept");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  c_call: cover property (call.req && call_ack);
  c_return_from_interrupt: cover property (return_from_interrupt_done);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // tli_ctrl_chk

bind tli_ctrl tli_ctrl_chk #(.N(N)) u_chk (.clk(clk), .rst_b(rst_b), .call(call),
  .call_ack(call_ack), .return_from_interrupt_done(return_from_interrupt_done), .instr_done(instr_done),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
